// ==== core/rmm_core.sv ====
// retentive memory manager: working ram, eeprom image copy and power sequencing
`include "rmm_regs.svh"

module rmm_core (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 power_fail,
	input  wire logic                 dl_start,
	input  wire logic                 dl_valid,
	input  wire logic [`RMM_AW-1:0]   dl_addr,
	input  wire logic [`RMM_DW-1:0]   dl_data,
	input  wire logic                 dl_done,
	input  wire logic                 cpu_req,
	input  wire logic                 cpu_we,
	input  wire logic [`RMM_AW-1:0]   cpu_addr,
	input  wire logic [`RMM_DW-1:0]   cpu_wdata,
	output logic                      cpu_ack,
	output logic      [`RMM_DW-1:0]   cpu_rdata,
	input  wire logic                 pgm_req,
	input  wire logic                 pgm_we,
	input  wire logic [`RMM_AW-1:0]   pgm_addr,
	input  wire logic [`RMM_DW-1:0]   pgm_wdata,
	output logic                      pgm_ack,
	output logic      [`RMM_DW-1:0]   pgm_rdata,
	output logic                      ee_req,
	output logic                      ee_we,
	output logic      [`RMM_EAW-1:0]  ee_addr,
	output logic      [`RMM_DW-1:0]   ee_wdata,
	input  wire logic                 ee_ack,
	input  wire logic [`RMM_DW-1:0]   ee_rdata,
	input  wire logic                 run_cmd,
	input  wire logic                 lost_clear,
	input  wire logic                 fault_clear,
	output logic                      retentive_lost_flag,
	output logic                      major_error,
	output logic                      running,
	output logic                      ready
);

	// ************************************************************
	// helpers
	// ************************************************************
	// true when a ram word belongs to the retentive region
	function automatic logic in_ret(input logic [`RMM_AW-1:0] a);
		in_ret = (a >= `RMM_RET_BASE);
	endfunction

	// ************************************************************
	// storage and state
	// ************************************************************
	logic [`RMM_DW-1:0]  ram [`RMM_RAM_WORDS];
	rmm_pkg::rmm_state_t state_ff, nxt_state;
	logic [4:0]          idx_ff;
	logic                pf_meta_ff, pf_sync_ff;
	logic                pd_path_ff, prio_ff, lost_ff, err_ff, run_ff, ready_ff;
	logic                ee_req_ff, ee_we_ff;
	logic [`RMM_EAW-1:0] ee_addr_ff;
	logic [`RMM_DW-1:0]  ee_wdata_ff;
	logic                cpu_ack_ff, pgm_ack_ff;
	logic [`RMM_DW-1:0]  cpu_rdata_ff, pgm_rdata_ff;

	// power-fail pin passes two flops before anyone looks at it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pf_meta_ff <= 1'b0;
			pf_sync_ff <= 1'b0;
		end else begin
			pf_meta_ff <= power_fail;
			pf_sync_ff <= pf_meta_ff;
		end
	end

	// ************************************************************
	// state decode
	// ************************************************************
	wire s_norm  = (state_ff == rmm_pkg::ST_NORMAL);
	wire s_dl    = (state_ff == rmm_pkg::ST_DL);
	wire s_ldp   = (state_ff == rmm_pkg::ST_LD_PGM);
	wire s_ldr   = (state_ff == rmm_pkg::ST_LD_RET);
	wire s_mrd   = (state_ff == rmm_pkg::ST_MARK_RD);
	wire s_mclr  = (state_ff == rmm_pkg::ST_MARK_CLR);
	wire s_mset  = (state_ff == rmm_pkg::ST_MARK_SET);
	wire s_stp   = (state_ff == rmm_pkg::ST_ST_PGM);
	wire s_stb   = (state_ff == rmm_pkg::ST_ST_BAK);
	wire s_str   = (state_ff == rmm_pkg::ST_ST_RET);
	wire s_load  = s_ldp | s_ldr;
	wire s_store = s_stp | s_stb | s_str;
	wire s_xfer  = s_load | s_store | s_mrd | s_mclr | s_mset;
	wire last    = (idx_ff == `RMM_LAST_IDX);
	wire step    = ee_ack & ee_req_ff;
	wire mark_ok = (ee_rdata == `RMM_MARK_VALID);

	// region base for ram side and eeprom side of the current copy
	wire [`RMM_AW-1:0] ram_base = (s_ldp | s_stp) ? `RMM_PGM_BASE
	                                              : `RMM_RET_BASE;
	wire [`RMM_AW-1:0] ram_ptr  = ram_base + {1'b0, idx_ff};
	wire [`RMM_EAW-1:0] img_base =
		(s_ldp | s_stp)            ? `RMM_EE_PGM :
		(s_stb | (s_ldr & lost_ff)) ? `RMM_EE_BAK : `RMM_EE_RET;
	wire [`RMM_EAW-1:0] img_ptr =
		(s_mrd | s_mclr | s_mset) ? `RMM_EE_MARK
		                          : img_base + {3'h0, idx_ff};

	// ************************************************************
	// sequencer
	// ************************************************************
	// saves and restores run a fixed chain; power fail only starts one
	// from normal and halts in download, a trade that keeps the chain simple
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			rmm_pkg::ST_MARK_RD:
				if (step) nxt_state = rmm_pkg::ST_LD_PGM;
			rmm_pkg::ST_LD_PGM:
				if (step && last) nxt_state = rmm_pkg::ST_LD_RET;
			rmm_pkg::ST_LD_RET:
				if (step && last) nxt_state = rmm_pkg::ST_NORMAL;
			rmm_pkg::ST_NORMAL:
				if (pf_sync_ff) nxt_state = rmm_pkg::ST_MARK_CLR;
				else if (dl_start) nxt_state = rmm_pkg::ST_DL;
			rmm_pkg::ST_DL:
				if (pf_sync_ff) nxt_state = rmm_pkg::ST_HALT;
				else if (dl_done) nxt_state = rmm_pkg::ST_MARK_CLR;
			rmm_pkg::ST_MARK_CLR:
				if (step) nxt_state = pd_path_ff ? rmm_pkg::ST_ST_RET
				                                 : rmm_pkg::ST_ST_PGM;
			rmm_pkg::ST_ST_PGM:
				if (step && last) nxt_state = rmm_pkg::ST_ST_BAK;
			rmm_pkg::ST_ST_BAK:
				if (step && last) nxt_state = rmm_pkg::ST_ST_RET;
			rmm_pkg::ST_ST_RET:
				if (step && last) nxt_state = rmm_pkg::ST_MARK_SET;
			rmm_pkg::ST_MARK_SET:
				if (step) nxt_state = pd_path_ff ? rmm_pkg::ST_HALT
				                                 : rmm_pkg::ST_NORMAL;
			rmm_pkg::ST_HALT:
				nxt_state = rmm_pkg::ST_HALT;
			default:
				nxt_state = rmm_pkg::ST_HALT;
		endcase
	end

	// state, word counter and which save chain is running
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff   <= rmm_pkg::ST_MARK_RD;
			idx_ff     <= 5'h00;
			pd_path_ff <= 1'b0;
			ready_ff   <= `RMM_RST_READY;
		end else begin
			state_ff   <= nxt_state;
			ready_ff   <= (nxt_state == rmm_pkg::ST_NORMAL);
			idx_ff     <= (nxt_state != state_ff) ? 5'h00
			            : step ? idx_ff + 5'h01 : idx_ff;
			if (s_norm) pd_path_ff <= pf_sync_ff;
		end
	end

	// ************************************************************
	// eeprom port
	// ************************************************************
	// request drops for one cycle after each ack so one word is never
	// taken twice; the eeprom is only touched by copy states
	wire nxt_ee_req = s_xfer & ~ee_ack;
	wire [`RMM_DW-1:0] nxt_ee_wdata =
		s_mset ? `RMM_MARK_VALID :
		s_mclr ? `RMM_MARK_CLEAR : ram[ram_ptr];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ee_req_ff   <= 1'b0;
			ee_we_ff    <= 1'b0;
			ee_addr_ff  <= `RMM_EE_MARK;
			ee_wdata_ff <= `RMM_MARK_CLEAR;
		end else begin
			ee_req_ff   <= nxt_ee_req;
			ee_we_ff    <= s_store | s_mclr | s_mset;
			ee_addr_ff  <= img_ptr;
			ee_wdata_ff <= nxt_ee_wdata;
		end
	end

	// ************************************************************
	// ram arbitration and write port
	// ************************************************************
	// rotating priority so neither master starves the other
	wire cpu_win  = s_norm & cpu_req & (~pgm_req | ~prio_ff);
	wire pgm_win  = s_norm & pgm_req & ~cpu_win;
	wire [`RMM_AW-1:0] usr_addr = cpu_win ? cpu_addr : pgm_addr;
	wire usr_we   = cpu_win ? cpu_we : pgm_we;
	wire [`RMM_DW-1:0] usr_data = cpu_win ? cpu_wdata : pgm_wdata;
	// writes to program words are acked but dropped while running
	wire usr_wr   = (cpu_win | pgm_win) & usr_we & in_ret(usr_addr);
	wire ld_wr    = s_load & step;
	wire dl_wr    = s_dl & dl_valid;
	wire wr_en    = usr_wr | ld_wr | dl_wr;
	wire [`RMM_AW-1:0] wr_addr = dl_wr ? dl_addr :
	                             ld_wr ? ram_ptr : usr_addr;
	wire [`RMM_DW-1:0] wr_data = dl_wr ? dl_data :
	                             ld_wr ? ee_rdata : usr_data;

	// single write port shared by download, restore and running writes
	always_ff @(posedge sys_clk) begin
		if (wr_en) ram[wr_addr] <= wr_data;
	end

	// answers: ack pulse one cycle after the grant, read data with it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prio_ff      <= 1'b0;
			cpu_ack_ff   <= 1'b0;
			pgm_ack_ff   <= 1'b0;
			cpu_rdata_ff <= 16'h0000;
			pgm_rdata_ff <= 16'h0000;
		end else begin
			if (cpu_win | pgm_win) prio_ff <= cpu_win;
			cpu_ack_ff <= cpu_win;
			pgm_ack_ff <= pgm_win;
			if (cpu_win) cpu_rdata_ff <= ram[cpu_addr];
			if (pgm_win) pgm_rdata_ff <= ram[pgm_addr];
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	// sets win over clears; lost is decided from the marker at boot
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lost_ff <= `RMM_RST_LOST;
			err_ff  <= `RMM_RST_ERR;
			run_ff  <= `RMM_RST_RUN;
		end else begin
			if (s_mrd && step) lost_ff <= ~mark_ok;
			else if (lost_clear) lost_ff <= 1'b0;
			if (run_cmd && s_norm && lost_ff) err_ff <= 1'b1;
			else if (fault_clear) err_ff <= 1'b0;
			if (run_cmd && s_norm) run_ff <= 1'b1;
			else if (!s_norm) run_ff <= 1'b0;
		end
	end

	assign cpu_ack             = cpu_ack_ff;
	assign pgm_ack             = pgm_ack_ff;
	assign cpu_rdata           = cpu_rdata_ff;
	assign pgm_rdata           = pgm_rdata_ff;
	assign ee_req              = ee_req_ff;
	assign ee_we               = ee_we_ff;
	assign ee_addr             = ee_addr_ff;
	assign ee_wdata            = ee_wdata_ff;
	assign retentive_lost_flag = lost_ff;
	assign major_error         = err_ff;
	assign running             = run_ff;
	assign ready               = ready_ff;

	// ************************************************************
	// checks
	// ************************************************************
	a_prog_read_only: assert property (@(posedge sys_clk) disable iff (rst)
		s_norm && usr_we && (cpu_win || pgm_win) && !in_ret(usr_addr)
		|=> ram[$past(usr_addr)] == $past(ram[usr_addr]))
		else $error("program region written while running");
	a_ee_idle_run: assert property (@(posedge sys_clk) disable iff (rst)
		s_norm && $past(s_norm) |-> !ee_req_ff)
		else $error("eeprom touched during normal operation");
	a_save_ret_only: assert property (@(posedge sys_clk) disable iff (rst)
		ee_req_ff && ee_we_ff && pd_path_ff |->
		ee_addr_ff >= `RMM_EE_RET)
		else $error("power-down save wrote outside retentive image");
	a_mark_last: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_mset) |-> $past(s_str) && $past(step) && $past(last))
		else $error("marker set before retentive image complete");
	a_lost_decide: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_ldp) |-> lost_ff == ($past(ee_rdata) != `RMM_MARK_VALID))
		else $error("lost flag does not follow marker");
	a_backup_src: assert property (@(posedge sys_clk) disable iff (rst)
		s_ldr && ee_req_ff |-> (ee_addr_ff < `RMM_EE_RET) == lost_ff)
		else $error("wrong retentive source at power-up");
	a_boot_order: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_norm) |-> $past(s_ldr) || $past(s_mset))
		else $error("normal entered without restore");
	a_run_error: assert property (@(posedge sys_clk) disable iff (rst)
		run_cmd && s_norm && lost_ff |=> err_ff && run_ff)
		else $error("run with lost data gave no major error");
	a_one_grant: assert property (@(posedge sys_clk) disable iff (rst)
		cpu_req && pgm_req && s_norm |=> cpu_ack_ff != pgm_ack_ff)
		else $error("arbiter granted none or both");
	a_dl_then_ee: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_stp) |-> $past(s_mclr) && !pd_path_ff)
		else $error("eeprom copy not preceded by download");

endmodule

// ==== core/rmm_regs.svh ====
// constants for the retentive memory manager: layout, markers, reset values
`ifndef RMM_REGS_SVH
`define RMM_REGS_SVH

// ************************************************************
// working ram layout (word addresses)
// ************************************************************
`define RMM_DW          16
`define RMM_AW          6
`define RMM_RAM_WORDS   64
`define RMM_PGM_BASE    6'h00
`define RMM_RET_BASE    6'h20
`define RMM_LAST_IDX    5'h1f

// ************************************************************
// eeprom image layout (word addresses)
// ************************************************************
`define RMM_EAW         8
`define RMM_EE_PGM      8'h00
`define RMM_EE_BAK      8'h40
`define RMM_EE_RET      8'h60
`define RMM_EE_MARK     8'h80
`define RMM_MARK_VALID  16'h5a5a
`define RMM_MARK_CLEAR  16'h0000

// ************************************************************
// reset values
// ************************************************************
`define RMM_RST_LOST    1'b0
`define RMM_RST_ERR     1'b0
`define RMM_RST_RUN     1'b0
`define RMM_RST_READY   1'b0

`endif

// ==== core/rmm_pkg.sv ====
// types shared by the retentive memory manager
package rmm_pkg;

	// ************************************************************
	// sequencer states, one-hot
	// ************************************************************
	typedef enum logic [11:0] {
		ST_MARK_RD  = 12'h001,
		ST_LD_PGM   = 12'h002,
		ST_LD_RET   = 12'h004,
		ST_NORMAL   = 12'h008,
		ST_DL       = 12'h010,
		ST_MARK_CLR = 12'h020,
		ST_ST_PGM   = 12'h040,
		ST_ST_BAK   = 12'h080,
		ST_ST_RET   = 12'h100,
		ST_MARK_SET = 12'h200,
		ST_HALT     = 12'h400,
		ST_SPARE    = 12'h800
	} rmm_state_t;

endpackage

// ==== testbench/rmm_ee_model.sv ====
// behavioural eeprom word store answering the core's request handshake
`include "rmm_regs.svh"

module rmm_ee_model (
	input  wire logic                sys_clk,
	input  wire logic                ee_req,
	input  wire logic                ee_we,
	input  wire logic [`RMM_EAW-1:0] ee_addr,
	input  wire logic [`RMM_DW-1:0]  ee_wdata,
	input  wire logic [2:0]          lat,
	output logic                     ee_ack,
	output logic      [`RMM_DW-1:0]  ee_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// storage and counters the bench inspects
	// ************************************************************
	logic [`RMM_DW-1:0] mem [0:255];
	logic [`RMM_DW-1:0] last_ff;
	logic [2:0]         cnt_ff;
	int                 n_wr;
	int                 n_low;

	// data only in the ack cycle; else inverse, so stale data never passes
	assign ee_rdata = ee_ack ? mem[ee_addr] : ~last_ff;

	initial begin
		ee_ack = 1'b0;
		cnt_ff = 3'h0;
		last_ff = 16'h0000;
		n_wr = 0;
		n_low = 0;
	end

	// ack after lat idle cycles; a dropped request restarts the count
	always @(posedge sys_clk) begin
		if (!ee_req || ee_ack) begin
			ee_ack <= 1'b0;
			cnt_ff <= 3'h0;
		end else if (cnt_ff == lat) begin
			ee_ack <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
		end
		if (ee_ack && ee_req) begin
			last_ff <= mem[ee_addr];
			if (ee_we) begin
				mem[ee_addr] <= ee_wdata;
				n_wr <= n_wr + 1;
				if (ee_addr < 8'h60) n_low <= n_low + 1;
			end
		end
	end
endmodule

// ==== testbench/test_retentive_memory_manager.sv ====
// self-checking bench for the retentive memory manager core
`include "rmm_regs.svh"

module test_retentive_memory_manager;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        power_fail = 1'b0;
	logic        dl_start = 1'b0;
	logic        dl_valid = 1'b0;
	logic [5:0]  dl_addr = 6'h00;
	logic [15:0] dl_data = 16'h0000;
	logic        dl_done = 1'b0;
	logic        cpu_req = 1'b0;
	logic        cpu_we = 1'b0;
	logic [5:0]  cpu_addr = 6'h00;
	logic [15:0] cpu_wdata = 16'h0000;
	logic        pgm_req = 1'b0;
	logic        pgm_we = 1'b0;
	logic [5:0]  pgm_addr = 6'h00;
	logic [15:0] pgm_wdata = 16'h0000;
	logic        run_cmd = 1'b0;
	logic        lost_clear = 1'b0;
	logic        fault_clear = 1'b0;
	logic [2:0]  lat = 3'h0;
	logic        cpu_ack, pgm_ack, ee_req, ee_we, ee_ack;
	logic        retentive_lost_flag, major_error, running, ready;
	logic [15:0] cpu_rdata, pgm_rdata, ee_wdata, ee_rdata, rd, rd2;
	logic [7:0]  ee_addr;
	int          n_errors = 0;
	int          cmp_count = 0;

	always #5 sys_clk = ~sys_clk;

	rmm_core rmm_core_inst (.sys_clk(sys_clk), .rst(rst),
		.power_fail(power_fail), .dl_start(dl_start), .dl_valid(dl_valid),
		.dl_addr(dl_addr), .dl_data(dl_data), .dl_done(dl_done),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.pgm_req(pgm_req), .pgm_we(pgm_we), .pgm_addr(pgm_addr),
		.pgm_wdata(pgm_wdata), .pgm_ack(pgm_ack), .pgm_rdata(pgm_rdata),
		.ee_req(ee_req), .ee_we(ee_we), .ee_addr(ee_addr),
		.ee_wdata(ee_wdata), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
		.run_cmd(run_cmd), .lost_clear(lost_clear),
		.fault_clear(fault_clear), .retentive_lost_flag(retentive_lost_flag),
		.major_error(major_error), .running(running), .ready(ready));

	rmm_ee_model rmm_ee_model_inst (.sys_clk(sys_clk), .ee_req(ee_req),
		.ee_we(ee_we), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .lat(lat),
		.ee_ack(ee_ack), .ee_rdata(ee_rdata));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task tick;
		@(posedge sys_clk);
		#1;
	endtask

	task conclude;
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick;
		s = 1'b0;
	endtask

	// hold the request until ack, drop it in the ack cycle
	task automatic access(input logic sel, input logic we, input logic [5:0] a,
		input logic [15:0] wd, output logic [15:0] q);
		logic got;
		got = 1'b0;
		if (sel) {pgm_req, pgm_we, pgm_addr, pgm_wdata} = {1'b1, we, a, wd};
		else {cpu_req, cpu_we, cpu_addr, cpu_wdata} = {1'b1, we, a, wd};
		for (int i = 0; i < 40 && !got; i++) begin
			tick;
			got = sel ? (pgm_ack === 1'b1) : (cpu_ack === 1'b1);
		end
		if (sel) pgm_req = 1'b0;
		else cpu_req = 1'b0;
		q = sel ? pgm_rdata : cpu_rdata;
		chk_bit("ram ack", 1'b1, got);
		if (!got) conclude;
		// one idle edge so a following call never re-raises req at once
		tick;
	endtask

	task wait_ready;
		for (int i = 0; i < 3000 && ready !== 1'b1; i++) tick;
		chk_bit("ready", 1'b1, ready);
		if (ready !== 1'b1) conclude;
	endtask

	task do_reset;
		rst = 1'b1;
		power_fail = 1'b0;
		repeat (3) tick;
		rst = 1'b0;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_boot_lost;
		for (int a = 0; a < 256; a++)
			rmm_ee_model_inst.mem[a] = 16'(a) + 16'h1000;
		rmm_ee_model_inst.mem[8'h80] = 16'h0000;
		do_reset;
		wait_ready;
		chk_bit("lost flag", 1'b1, retentive_lost_flag);
		access(0, 0, 6'h05, 16'h0000, rd);
		chk_word("program word", 16'h1005, rd);
		access(1, 0, 6'h25, 16'h0000, rd);
		chk_word("backup as retentive", 16'h1045, rd);
		chk_bit("error before run", 1'b0, major_error);
		pulse(run_cmd);
		chk_bit("running", 1'b1, running);
		chk_bit("error at run", 1'b1, major_error);
		pulse(fault_clear);
		pulse(lost_clear);
		chk_bit("error cleared", 1'b0, major_error);
		chk_bit("lost cleared", 1'b0, retentive_lost_flag);
	endtask

	task t_access;
		int w0;
		w0 = rmm_ee_model_inst.n_wr;
		access(0, 1, 6'h03, 16'hdead, rd);
		access(1, 1, 6'h1f, 16'hbeef, rd);
		access(0, 0, 6'h03, 16'h0000, rd);
		chk_word("program read-only", 16'h1003, rd);
		access(0, 0, 6'h1f, 16'h0000, rd);
		chk_word("program read-only", 16'h101f, rd);
		access(0, 1, 6'h21, 16'h00c1, rd);
		// both masters at once must each be served
		fork
			access(0, 0, 6'h1f, 16'h0000, rd);
			access(1, 0, 6'h21, 16'h0000, rd2);
		join
		chk_word("cpu shared read", 16'h101f, rd);
		chk_word("pgm sees cpu write", 16'h00c1, rd2);
		chk_word("ee untouched", 16'(w0), 16'(rmm_ee_model_inst.n_wr));
	endtask

	task t_download;
		lat = 3'h3;
		pulse(dl_start);
		chk_bit("ready in download", 1'b0, ready);
		dl_valid = 1'b1;
		for (int a = 0; a < 64; a++) begin
			dl_addr = 6'(a);
			dl_data = 16'(a) + 16'h2000;
			tick;
		end
		dl_valid = 1'b0;
		pulse(dl_done);
		wait_ready;
		for (int a = 0; a < 32; a++) begin
			rd = rmm_ee_model_inst.mem[a];
			chk_word("ee program", 16'(a) + 16'h2000, rd);
			rd = rmm_ee_model_inst.mem[8'h40 + a];
			chk_word("ee backup", 16'(a) + 16'h2020, rd);
			rd = rmm_ee_model_inst.mem[8'h60 + a];
			chk_word("ee retentive", 16'(a) + 16'h2020, rd);
		end
		chk_word("marker", 16'h5a5a, rmm_ee_model_inst.mem[8'h80]);
		access(1, 0, 6'h10, 16'h0000, rd);
		chk_word("ram after download", 16'h2010, rd);
		lat = 3'h0;
	endtask

	task t_save;
		int  low;
		logic cleared, done;
		{cleared, done} = 2'b00;
		access(0, 1, 6'h30, 16'hbeef, rd);
		low = rmm_ee_model_inst.n_low;
		power_fail = 1'b1;
		for (int i = 0; i < 2000 && !done; i++) begin
			tick;
			if (rmm_ee_model_inst.mem[8'h80] === 16'h0000) cleared = 1'b1;
			done = cleared && rmm_ee_model_inst.mem[8'h80] === 16'h5a5a;
		end
		chk_bit("marker cleared then set", 1'b1, done);
		chk_word("saved retentive", 16'hbeef, rmm_ee_model_inst.mem[8'h70]);
		chk_word("no program rewrite", 16'(low), 16'(rmm_ee_model_inst.n_low));
	endtask

	task t_boot_ok;
		do_reset;
		wait_ready;
		chk_bit("lost flag intact", 1'b0, retentive_lost_flag);
		access(0, 0, 6'h30, 16'h0000, rd);
		chk_word("restored retentive", 16'hbeef, rd);
		access(1, 0, 6'h10, 16'h0000, rd);
		chk_word("restored program", 16'h2010, rd);
	endtask

	// reset lands in mid-save, so the image must count as lost
	task t_cut;
		int k;
		k = 0;
		power_fail = 1'b1;
		for (int i = 0; i < 300 && k < 4; i++) begin
			tick;
			if (ee_ack === 1'b1) k++;
		end
		chk_bit("cut point reached", 1'b1, k == 4);
		do_reset;
		wait_ready;
		chk_bit("lost after cut save", 1'b1, retentive_lost_flag);
		access(0, 0, 6'h30, 16'h0000, rd);
		chk_word("backup after cut", 16'h2030, rd);
		pulse(run_cmd);
		chk_bit("error at run", 1'b1, major_error);
	endtask

	// power fail in download halts with no eeprom write at all
	task t_dl_cut;
		int w0;
		w0 = rmm_ee_model_inst.n_wr;
		pulse(dl_start);
		power_fail = 1'b1;
		repeat (12) tick;
		chk_bit("eeprom idle after cut", 1'b0, ee_req);
		chk_bit("halted after cut", 1'b0, ready);
		rd = 16'(rmm_ee_model_inst.n_wr);
		chk_word("no save from download", 16'(w0), rd);
	endtask

	initial begin
		t_boot_lost;
		t_access;
		t_download;
		t_save;
		t_boot_ok;
		t_cut;
		t_dl_cut;
		conclude;
	end
endmodule
